// ===== hdl/core_special_function_regs.sv
// Core special function register bank with APB access, flags and table read.
//
// Implementation choices: register access over APB and the address map.
`timescale 1ns/1ps
module core_special_function_regs
  import csfr_pkg::*;
(
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // ALU operation from the instruction core.
  input wire logic alu_valid,
  input wire alu_req_s alu_req,
  output logic [7:0] working_reg,
  // Program flow.
  input wire logic jump_req,
  input wire logic [12:0] jump_target,
  output logic [13:0] pc,
  output logic dummy_cycle,
  // Extended data memory addressing.
  input wire logic ext_valid,
  input wire logic [11:0] ext_addr,
  output ext_addr_s ext_split,
  // Table read and program/option memory.
  input wire logic table_read_op,
  input wire logic table_read_last_op,
  output logic [13:0] pmem_addr,
  output logic pmem_rd,
  input wire logic [15:0] pmem_rdata,
  output logic [4:0] opt_addr,
  output logic opt_rd,
  input wire logic [15:0] opt_rdata,
  output logic [7:0] table_low_data,
  output logic table_done,
  // System events.
  input wire logic halt_op,
  input wire logic watchdog_clear_op,
  input wire logic wdt_timeout,
  input wire logic wake_event,
  input wire logic slow_rc_osc,
  output logic option_map_active
);
  function automatic logic [10:0] add8(input logic [7:0] x, input logic [7:0] y,
                                       input logic cin);
    logic [4:0] lo;
    logic [7:0] low7;
    logic [8:0] full;
    lo = {1'b0, x[3:0]} + {1'b0, y[3:0]} + {4'h0, cin};
    low7 = {1'b0, x[6:0]} + {1'b0, y[6:0]} + {7'h00, cin};
    full = {1'b0, x} + {1'b0, y} + {8'h00, cin};
    // Packed as {carry, nibble carry, overflow, result}.
    add8 = {full[8], lo[4], full[8] ^ low7[7], full[7:0]};
  endfunction

  function automatic logic in_window(input logic [7:0] lo);
    in_window = lo >= OPT_WIN_BASE;
  endfunction

  logic bank_select_bit;
  logic [7:0] table_pointer_low;
  logic [7:0] table_pointer_high;
  logic [7:0] table_high_result;
  logic [7:0] option_map_unlock;
  logic [7:0] arith_system_flags;
  logic tbl_pending;
  logic tbl_from_opt;
  logic map_en;

  // Bus decode.
  wire setup = psel && !penable;
  wire xfer_done = psel && penable && pready;
  wire wr_en = xfer_done && pwrite;
  wire [7:0] wbyte = pwdata[7:0];
  wire hit_bank = paddr == OFS_BANK;
  wire hit_pcl = paddr == OFS_PCL;
  wire hit_tlo = paddr == OFS_TBL_LO;
  wire hit_thi = paddr == OFS_TBL_HI;
  wire hit_tres = paddr == OFS_TBL_RES;
  wire hit_unl = paddr == OFS_UNLOCK;
  wire hit_flg = paddr == OFS_FLAGS;
  wire hit_wreg = paddr == OFS_WREG;
  wire mapped = hit_bank | hit_pcl | hit_tlo | hit_thi | hit_tres | hit_unl | hit_flg
                | hit_wreg;
  wire [7:0] rd_byte =
    hit_bank ? {7'h00, bank_select_bit} :
    hit_pcl ? pc[7:0] :
    hit_tlo ? table_pointer_low :
    hit_thi ? table_pointer_high :
    hit_tres ? table_high_result :
    hit_unl ? option_map_unlock :
    hit_flg ? arith_system_flags :
    hit_wreg ? working_reg : 8'h00;

  // One wait-free access phase: pready rises in the first access cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= setup;
      pslverr <= setup && !mapped;
      prdata <= (setup && !pwrite) ? {24'h000000, rd_byte} : 32'h00000000;
    end
  end

  // ALU arithmetic and flag evaluation.
  wire is_sub = alu_req.op == OP_SUB || alu_req.op == OP_SBC;
  wire is_carry_op = alu_req.op == OP_ADC || alu_req.op == OP_SBC;
  wire is_arith = alu_req.op == OP_ADD || is_carry_op || is_sub;
  wire is_rot = alu_req.op == OP_RLC || alu_req.op == OP_RRC;
  wire [7:0] opnd_b = is_sub ? ~alu_req.b : alu_req.b;
  wire cin = is_carry_op ? arith_system_flags[FLG_C] : (alu_req.op == OP_SUB);
  wire [10:0] sum = add8(alu_req.a, opnd_b, cin);
  wire [7:0] next_result =
    is_arith ? sum[7:0] :
    alu_req.op == OP_AND ? alu_req.a & alu_req.b :
    alu_req.op == OP_OR ? alu_req.a | alu_req.b :
    alu_req.op == OP_XOR ? alu_req.a ^ alu_req.b :
    alu_req.op == OP_RLC ? {alu_req.a[6:0], arith_system_flags[FLG_C]} :
    alu_req.op == OP_RRC ? {arith_system_flags[FLG_C], alu_req.a[7:1]} : alu_req.a;
  wire next_z = next_result == 8'h00;
  wire next_ov = is_arith ? sum[8] : arith_system_flags[FLG_OV];
  wire next_c = is_arith ? sum[10] :
                alu_req.op == OP_RLC ? alu_req.a[7] :
                alu_req.op == OP_RRC ? alu_req.a[0] : arith_system_flags[FLG_C];
  wire next_cz = alu_req.op == OP_SUB ? next_z :
                 alu_req.op == OP_SBC ? (arith_system_flags[FLG_CZ] & next_z) :
                 arith_system_flags[FLG_CZ];

  // Flags register; flags are never stacked, so only these paths alter them.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      arith_system_flags <= FLAGS_RST;
      working_reg <= BYTE_RST;
    end else begin
      if (wr_en && hit_flg) begin
        arith_system_flags[FLG_SC] <= wbyte[FLG_SC];
        arith_system_flags[FLG_CZ] <= wbyte[FLG_CZ];
        arith_system_flags[FLG_OV:FLG_C] <= wbyte[FLG_OV:FLG_C];
      end
      if (alu_valid) begin
        working_reg <= next_result;
        arith_system_flags[FLG_C] <= next_c;
        if (!is_rot) begin
          arith_system_flags[FLG_Z] <= next_z;
          arith_system_flags[FLG_SC] <= next_ov ^ next_result[7];
          arith_system_flags[FLG_CZ] <= next_cz;
        end
        if (is_arith) begin
          arith_system_flags[FLG_AC] <= sum[9];
          arith_system_flags[FLG_OV] <= sum[8];
        end
      end
      // Set wins over a clear in the same cycle.
      if (wdt_timeout) begin
        arith_system_flags[FLG_TO] <= 1'b1;
      end else if (watchdog_clear_op || halt_op) begin
        arith_system_flags[FLG_TO] <= 1'b0;
      end
      if (halt_op) begin
        arith_system_flags[FLG_PDF] <= 1'b1;
      end else if (watchdog_clear_op) begin
        arith_system_flags[FLG_PDF] <= 1'b0;
      end
    end
  end

  // Program counter, bank select and page-local jumps.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bank_select_bit <= 1'b0;
      pc <= PC_RST;
      dummy_cycle <= 1'b0;
    end else begin
      dummy_cycle <= wr_en && hit_pcl;
      if (wr_en && hit_bank) begin
        bank_select_bit <= wbyte[0];
      end
      if (wr_en && hit_pcl) begin
        pc <= {pc[13:8], wbyte};
      end else if (jump_req) begin
        pc <= {bank_select_bit, jump_target};
      end
    end
  end

  // Extended address split and table pointers.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_split <= '0;
      table_pointer_low <= BYTE_RST;
      table_pointer_high <= BYTE_RST;
    end else begin
      if (ext_valid) begin
        ext_split.sector <= ext_addr[SECTOR_MSB:SECTOR_LSB];
        ext_split.offset <= ext_addr[SECTOR_LSB-1:0];
      end
      if (wr_en && hit_tlo) begin
        table_pointer_low <= wbyte;
      end
      if (wr_en && hit_thi) begin
        table_pointer_high <= wbyte;
      end
    end
  end

  // Table read: address cycle, then data capture one cycle later.
  wire [5:0] tbl_page = table_read_last_op ? LAST_PAGE : table_pointer_high[5:0];
  wire tbl_req = table_read_op || table_read_last_op;
  wire use_opt = map_en && tbl_page == LAST_PAGE && in_window(table_pointer_low);
  wire [15:0] tbl_word = tbl_from_opt ? opt_rdata : pmem_rdata;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pmem_addr <= PC_RST;
      pmem_rd <= 1'b0;
      opt_addr <= 5'h00;
      opt_rd <= 1'b0;
      tbl_pending <= 1'b0;
      tbl_from_opt <= 1'b0;
      table_done <= 1'b0;
      table_low_data <= BYTE_RST;
      table_high_result <= BYTE_RST;
    end else begin
      pmem_rd <= tbl_req && !use_opt;
      opt_rd <= tbl_req && use_opt;
      tbl_pending <= tbl_req;
      table_done <= tbl_pending;
      if (tbl_req) begin
        pmem_addr <= {tbl_page, table_pointer_low};
        opt_addr <= table_pointer_low[4:0];
        tbl_from_opt <= use_opt;
      end
      if (tbl_pending) begin
        table_high_result <= tbl_word[15:8];
        table_low_data <= tbl_word[7:0];
      end
    end
  end

  // Unlock register: plain storage, cleared on wake from idle or sleep.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      option_map_unlock <= UNLOCK_RST;
      option_map_active <= 1'b0;
    end else begin
      option_map_active <= map_en;
      if (wake_event) begin
        option_map_unlock <= UNLOCK_RST;
      end else if (wr_en && hit_unl) begin
        option_map_unlock <= wbyte;
      end
    end
  end

  // Every bus transfer, ALU step or table read counts as one instruction cycle.
  wire instr_cycle = xfer_done || alu_valid || tbl_req;

  option_map_timer u_map_timer (
    .pclk(pclk),
    .presetn(presetn),
    .instr_cycle(instr_cycle),
    .unlock_wr(wr_en && hit_unl),
    .unlock_data(wbyte),
    .slow_rc_osc(slow_rc_osc),
    .map_en(map_en)
  );

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  wire flg_wr = wr_en && hit_flg;

  a_bank_upper_zero: assert property (
    setup && !pwrite && hit_bank |=> prdata[31:1] == 31'h0)
    else $error("Bank select upper bits did not read zero.");
  a_pcl_page_jump: assert property (
    wr_en && hit_pcl |=> dummy_cycle && pc == {$past(pc[13:8]), $past(wbyte)})
    else $error("Low byte write did not jump within the page.");
  a_jump_bank_bit: assert property (
    jump_req && !(wr_en && hit_pcl) |=> pc == {$past(bank_select_bit), $past(jump_target)})
    else $error("Jump target ignored the bank select bit.");
  a_sector_split: assert property (
    ext_valid |=> ext_split.sector == $past(ext_addr[SECTOR_MSB:SECTOR_LSB])
    && ext_split.offset == $past(ext_addr[SECTOR_LSB-1:0]))
    else $error("Extended address was not split into sector and offset.");
  a_table_read_done: assert property (tbl_req |-> ##2 table_done)
    else $error("Table read did not complete in two cycles.");
  a_table_high_byte: assert property (
    tbl_req && !use_opt ##1 1 |=> table_high_result == $past(pmem_rdata[15:8]))
    else $error("Table high result does not match fetched word.");
  a_option_route: assert property (
    tbl_req && use_opt |=> opt_rd && !pmem_rd && opt_addr == $past(table_pointer_low[4:0]))
    else $error("Mapped table read did not reach option memory.");
  a_status_protect: assert property (
    flg_wr && !halt_op && !watchdog_clear_op && !wdt_timeout
    |=> $stable(arith_system_flags[FLG_TO:FLG_PDF]))
    else $error("Flag write altered protected flags.");
  a_halt_sleep_flag: assert property (
    halt_op && !wdt_timeout |=> arith_system_flags[FLG_PDF] && !arith_system_flags[FLG_TO])
    else $error("Halt did not set sleep flag and clear watchdog flag.");
  a_timeout_sets_to: assert property (wdt_timeout |=> arith_system_flags[FLG_TO])
    else $error("Watchdog time-out did not set its flag.");
  a_zero_and_sign: assert property (
    alu_valid && !is_rot |=> arith_system_flags[FLG_Z] == (working_reg == 8'h00)
    && arith_system_flags[FLG_SC] == (arith_system_flags[FLG_OV] ^ working_reg[7]))
    else $error("Zero or sign flag disagrees with the result.");
  a_rotate_carry: assert property (
    alu_valid && alu_req.op == OP_RLC |=> arith_system_flags[FLG_C] == $past(alu_req.a[7])
    && working_reg == {$past(alu_req.a[6:0]), $past(arith_system_flags[FLG_C])})
    else $error("Rotate left through carry gave a wrong carry or result.");
  a_chained_zero: assert property (
    alu_valid && alu_req.op == OP_SBC
    |=> arith_system_flags[FLG_CZ]
    == ($past(arith_system_flags[FLG_CZ]) && working_reg == 8'h00))
    else $error("Chained zero flag after subtract with carry is wrong.");
  a_wake_clears_unl: assert property (wake_event |=> option_map_unlock == UNLOCK_RST)
    else $error("Wake did not clear the unlock register.");
endmodule

// ===== shared/csfr_pkg.sv
// Constants, types and register map of the core special function registers.
package csfr_pkg;
  // Register byte offsets on the APB bus.
  localparam logic [11:0] OFS_BANK = 12'h000;
  localparam logic [11:0] OFS_PCL = 12'h004;
  localparam logic [11:0] OFS_TBL_LO = 12'h008;
  localparam logic [11:0] OFS_TBL_HI = 12'h00C;
  localparam logic [11:0] OFS_TBL_RES = 12'h010;
  localparam logic [11:0] OFS_UNLOCK = 12'h014;
  localparam logic [11:0] OFS_FLAGS = 12'h018;
  localparam logic [11:0] OFS_WREG = 12'h01C;
  // Reset values.
  localparam logic [7:0] BANK_RST = 8'h00;
  localparam logic [7:0] UNLOCK_RST = 8'h00;
  localparam logic [7:0] FLAGS_RST = 8'h00;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [13:0] PC_RST = 14'h0000;
  // Flag bit positions.
  localparam int FLG_SC = 7;
  localparam int FLG_CZ = 6;
  localparam int FLG_TO = 5;
  localparam int FLG_PDF = 4;
  localparam int FLG_OV = 3;
  localparam int FLG_Z = 2;
  localparam int FLG_AC = 1;
  localparam int FLG_C = 0;
  // Unlock pattern and mapping window.
  localparam logic [7:0] UNLOCK_FIRST = 8'h55;
  localparam logic [7:0] UNLOCK_SECOND = 8'hAA;
  localparam logic [2:0] MAP_RC_PERIODS = 3'h4;
  // Program memory paging, option memory window and data memory sectors.
  localparam logic [5:0] LAST_PAGE = 6'h3F;
  localparam logic [7:0] OPT_WIN_BASE = 8'hE0;
  localparam int SECTOR_MSB = 11;
  localparam int SECTOR_LSB = 8;

  typedef enum logic [3:0] {
    OP_ADD, OP_ADC, OP_SUB, OP_SBC, OP_AND, OP_OR, OP_XOR, OP_RLC, OP_RRC, OP_MOVE
  } alu_op_e;

  typedef struct packed {
    alu_op_e op;
    logic [7:0] a;
    logic [7:0] b;
  } alu_req_s;

  typedef struct packed {
    logic [3:0] sector;
    logic [7:0] offset;
  } ext_addr_s;

  typedef enum logic {SEQ_IDLE, SEQ_ARMED} unlock_seq_e;
endpackage

// ===== hdl/option_map_timer.sv
// Unlock pattern sequencer and self-expiring option memory mapping window.
`timescale 1ns/1ps
module option_map_timer
  import csfr_pkg::*;
(
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Instruction cycle events.
  input wire logic instr_cycle,
  input wire logic unlock_wr,
  input wire logic [7:0] unlock_data,
  // Slow oscillator level.
  input wire logic slow_rc_osc,
  // Mapping state.
  output logic map_en
);
  unlock_seq_e seq;
  unlock_seq_e next_seq;
  logic [2:0] rc_count;
  logic rc_prev;
  wire rc_rise = slow_rc_osc && !rc_prev;
  wire first_ok = unlock_wr && (unlock_data == UNLOCK_FIRST);
  wire success = unlock_wr && (unlock_data == UNLOCK_SECOND) && (seq == SEQ_ARMED);
  wire expire = map_en && rc_rise && (rc_count == MAP_RC_PERIODS - 3'h1);

  // Any other instruction cycle between the two bytes drops the sequence.
  always_comb begin
    case (seq)
      SEQ_IDLE: next_seq = first_ok ? SEQ_ARMED : SEQ_IDLE;
      SEQ_ARMED: next_seq = first_ok ? SEQ_ARMED : (instr_cycle ? SEQ_IDLE : SEQ_ARMED);
      default: next_seq = SEQ_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seq <= SEQ_IDLE;
      rc_prev <= 1'b0;
      map_en <= 1'b0;
      rc_count <= 3'h0;
    end else begin
      seq <= next_seq;
      rc_prev <= slow_rc_osc;
      if (success) begin
        map_en <= 1'b1;
        rc_count <= 3'h0;
      end else if (expire) begin
        map_en <= 1'b0;
        rc_count <= 3'h0;
      end else if (map_en && rc_rise) begin
        rc_count <= rc_count + 3'h1;
      end
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_first_byte;
    unlock_wr && unlock_data == UNLOCK_FIRST;
  endsequence
  sequence s_second_byte;
    unlock_wr && unlock_data == UNLOCK_SECOND;
  endsequence

  // Counts slow rising edges since the last completed pattern, apart from the window logic.
  logic [2:0] rises_since;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rises_since <= 3'h0;
    end else if (success) begin
      rises_since <= 3'h0;
    end else if (rc_rise && rises_since != 3'h7) begin
      rises_since <= rises_since + 3'h1;
    end
  end

  // The checked spacing is one idle and one setup cycle between two bus writes.
  a_unlock_pattern_maps: assert property (
    s_first_byte ##1 (!instr_cycle)[*2] ##1 s_second_byte |=> map_en)
    else $error("Back-to-back unlock pattern did not enable mapping.");
  a_broken_pattern_off: assert property (
    (!map_en && unlock_wr && unlock_data == UNLOCK_FIRST) ##1 (!instr_cycle)[*2]
    ##1 (instr_cycle && !unlock_wr) ##1 (!instr_cycle)[*2] ##1 s_second_byte |=> !map_en)
    else $error("Mapping enabled although the pattern was interrupted.");
  a_window_expires: assert property (rises_since >= MAP_RC_PERIODS |-> !map_en)
    else $error("Mapping window did not end after four slow periods.");
endmodule

// ===== verif/core_special_function_regs_tb.sv
// Self-checking testbench for the core special function register bank.
`timescale 1ns/1ps
module core_special_function_regs_tb
  import csfr_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr, ext_addr;
  logic [31:0] pwdata, prdata, rd;
  logic alu_valid, jump_req, dummy_cycle, ext_valid, table_read_op, table_read_last_op;
  alu_req_s alu_req;
  logic [7:0] working_reg, table_low_data;
  logic [12:0] jump_target;
  logic [13:0] pc, pmem_addr, last_pmem;
  ext_addr_s ext_split;
  logic pmem_rd, opt_rd, table_done, option_map_active;
  logic [15:0] pmem_rdata, opt_rdata;
  logic [4:0] opt_addr, last_opt;
  logic halt_op, watchdog_clear_op, wdt_timeout, wake_event, slow_rc_osc;
  int num_errors, comparisons, cycles, dummy_seen, d0;

  core_special_function_regs i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .alu_valid(alu_valid), .alu_req(alu_req), .working_reg(working_reg),
    .jump_req(jump_req), .jump_target(jump_target), .pc(pc), .dummy_cycle(dummy_cycle),
    .ext_valid(ext_valid), .ext_addr(ext_addr), .ext_split(ext_split),
    .table_read_op(table_read_op), .table_read_last_op(table_read_last_op),
    .pmem_addr(pmem_addr), .pmem_rd(pmem_rd), .pmem_rdata(pmem_rdata),
    .opt_addr(opt_addr), .opt_rd(opt_rd), .opt_rdata(opt_rdata),
    .table_low_data(table_low_data), .table_done(table_done), .halt_op(halt_op),
    .watchdog_clear_op(watchdog_clear_op), .wdt_timeout(wdt_timeout),
    .wake_event(wake_event), .slow_rc_osc(slow_rc_osc), .option_map_active(option_map_active)
  );

  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  task automatic test_done();
    $display("comparisons %0d errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Watches one-cycle outputs and cuts a hang short.
  always @(posedge pclk) begin
    if (dummy_cycle === 1'b1) dummy_seen++;
    if (opt_rd === 1'b1) last_opt = opt_addr;
    if (pmem_rd === 1'b1) last_pmem = pmem_addr;
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      test_done();
    end
  end

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rchk(input string name, input logic [11:0] a, input logic [7:0] exp);
    apb(1'b0, a, 8'h00);
    chk(name, rd, {24'h000000, exp});
  endtask

  task automatic alu(input alu_op_e op, input logic [7:0] a, input logic [7:0] b);
    @(posedge pclk);
    alu_valid <= 1'b1;
    alu_req <= '{op: op, a: a, b: b};
    @(posedge pclk);
    alu_valid <= 1'b0;
  endtask

  task automatic tread(input logic last);
    @(posedge pclk);
    table_read_op <= ~last;
    table_read_last_op <= last;
    @(posedge pclk);
    table_read_op <= 1'b0;
    table_read_last_op <= 1'b0;
    while (table_done !== 1'b1) begin
      @(posedge pclk);
    end
  endtask

  task automatic rc_edges(input int k);
    repeat (k) begin
      @(posedge pclk);
      slow_rc_osc <= 1'b1;
      repeat (3) @(posedge pclk);
      slow_rc_osc <= 1'b0;
      repeat (3) @(posedge pclk);
    end
  endtask

  task automatic unlock();
    apb(1'b1, OFS_UNLOCK, UNLOCK_FIRST);
    apb(1'b1, OFS_UNLOCK, UNLOCK_SECOND);
    repeat (2) @(posedge pclk);
  endtask

  initial begin
    {presetn, psel, penable, pwrite, alu_valid, jump_req, ext_valid} = '0;
    {table_read_op, table_read_last_op, halt_op, watchdog_clear_op} = '0;
    {wdt_timeout, wake_event, slow_rc_osc} = '0;
    paddr = '0;
    pwdata = '0;
    alu_req = '0;
    jump_target = '0;
    ext_addr = '0;
    pmem_rdata = 16'hA55A;
    opt_rdata = 16'hC33C;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rchk("bank", OFS_BANK, BANK_RST);
    rchk("unlock", OFS_UNLOCK, UNLOCK_RST);
    rchk("flags", OFS_FLAGS, FLAGS_RST);
    apb(1'b1, OFS_BANK, 8'hFF);
    rchk("bank", OFS_BANK, 8'h01);
    for (int i = 1; i >= 0; i--) begin
      apb(1'b1, OFS_BANK, 8'(i));
      @(posedge pclk);
      jump_req <= 1'b1;
      jump_target <= 13'h0A55;
      @(posedge pclk);
      jump_req <= 1'b0;
      @(posedge pclk);
      chk("pc", 32'(pc), 32'({i[0], 13'h0A55}));
    end
    d0 = dummy_seen;
    apb(1'b1, OFS_PCL, 8'h12);
    repeat (3) @(posedge pclk);
    chk("dummy", 32'(dummy_seen - d0), 32'd1);
    chk("pc", 32'(pc), 32'h0A12);
    @(posedge pclk);
    ext_valid <= 1'b1;
    ext_addr <= 12'h1F0;
    @(posedge pclk);
    ext_valid <= 1'b0;
    @(posedge pclk);
    chk("ext", 32'(ext_split), 32'h1F0);
    alu(OP_ADD, 8'h80, 8'h80);
    rchk("flags", OFS_FLAGS, 8'h8D);
    alu(OP_SUB, 8'h05, 8'h05);
    rchk("flags", OFS_FLAGS, 8'h47);
    alu(OP_SBC, 8'h03, 8'h03);
    rchk("flags", OFS_FLAGS, 8'h47);
    alu(OP_SBC, 8'h04, 8'h03);
    rchk("flags", OFS_FLAGS, 8'h03);
    alu(OP_RLC, 8'h40, 8'h00);
    rchk("flags", OFS_FLAGS, 8'h02);
    apb(1'b1, OFS_WREG, 8'h77);
    rchk("wreg", OFS_WREG, 8'h81);
    chk("wreg_port", 32'(working_reg), 32'h81);
    apb(1'b1, OFS_FLAGS, 8'hFF);
    rchk("flags", OFS_FLAGS, 8'hCF);
    @(posedge pclk);
    halt_op <= 1'b1;
    @(posedge pclk);
    halt_op <= 1'b0;
    rchk("flags", OFS_FLAGS, 8'hDF);
    @(posedge pclk);
    wdt_timeout <= 1'b1;
    @(posedge pclk);
    wdt_timeout <= 1'b0;
    apb(1'b1, OFS_FLAGS, 8'h00);
    rchk("flags", OFS_FLAGS, 8'h30);
    @(posedge pclk);
    watchdog_clear_op <= 1'b1;
    @(posedge pclk);
    watchdog_clear_op <= 1'b0;
    rchk("flags", OFS_FLAGS, 8'h00);
    alu(OP_ADC, 8'h7F, 8'h01);
    rchk("flags", OFS_FLAGS, 8'h0A);
    alu(OP_RRC, 8'h01, 8'h00);
    rchk("flags", OFS_FLAGS, 8'h0B);
    alu(OP_AND, 8'hF0, 8'h0F);
    rchk("flags", OFS_FLAGS, 8'h8F);
    alu(OP_XOR, 8'hFF, 8'h7F);
    rchk("flags", OFS_FLAGS, 8'h0B);
    alu(OP_OR, 8'h00, 8'h00);
    rchk("flags", OFS_FLAGS, 8'h8F);
    alu(OP_MOVE, 8'h5A, 8'h00);
    rchk("flags", OFS_FLAGS, 8'h8B);
    chk("wreg_port", 32'(working_reg), 32'h5A);
    apb(1'b1, OFS_TBL_HI, 8'h01);
    apb(1'b1, OFS_TBL_LO, 8'h23);
    tread(1'b0);
    chk("pmem", 32'(last_pmem), 32'h0123);
    chk("tlow", 32'(table_low_data), 32'h5A);
    rchk("thigh", OFS_TBL_RES, 8'hA5);
    apb(1'b1, OFS_UNLOCK, UNLOCK_FIRST);
    apb(1'b0, OFS_BANK, 8'h00);
    apb(1'b1, OFS_UNLOCK, UNLOCK_SECOND);
    repeat (2) @(posedge pclk);
    chk("map", 32'(option_map_active), 32'd0);
    unlock();
    chk("map", 32'(option_map_active), 32'd1);
    rchk("unlock", OFS_UNLOCK, UNLOCK_SECOND);
    apb(1'b1, OFS_TBL_HI, 8'h3F);
    apb(1'b1, OFS_TBL_LO, 8'hE3);
    tread(1'b0);
    chk("opt", 32'(last_opt), 32'd3);
    chk("tlow", 32'(table_low_data), 32'h3C);
    apb(1'b1, OFS_TBL_HI, 8'h00);
    apb(1'b1, OFS_TBL_LO, 8'hE5);
    tread(1'b1);
    chk("opt", 32'(last_opt), 32'd5);
    rc_edges(2);
    unlock();
    rc_edges(3);
    chk("map", 32'(option_map_active), 32'd1);
    rc_edges(1);
    chk("map", 32'(option_map_active), 32'd0);
    apb(1'b1, OFS_TBL_HI, 8'h3F);
    apb(1'b1, OFS_TBL_LO, 8'hE3);
    tread(1'b0);
    chk("pmem", 32'(last_pmem), 32'h3FE3);
    apb(1'b1, OFS_UNLOCK, 8'h5A);
    @(posedge pclk);
    wake_event <= 1'b1;
    @(posedge pclk);
    wake_event <= 1'b0;
    rchk("unlock", OFS_UNLOCK, 8'h00);
    rchk("unmapped", 12'h020, 8'h00);
    chk("slverr", 32'(err), 32'd1);
    test_done();
  end
endmodule
